// *** hw/dccr_pkg.sv ***
package dccr_pkg;

    localparam logic [7:0] ADDR_CHAN_B_LOW  = 8'h12;
    localparam logic [7:0] ADDR_CHAN_B_HIGH = 8'h13;
    localparam logic [7:0] ADDR_CHAN_C_LOW  = 8'h14;
    localparam logic [7:0] ADDR_CHAN_C_HIGH = 8'h15;
    localparam logic [7:0] ADDR_CHAN_D_LOW  = 8'h16;
    localparam logic [7:0] ADDR_CHAN_D_HIGH = 8'h17;
    localparam logic [7:0] ADDR_PRIMARY_CFG = 8'h18;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] LOW_MASK_12BIT = 8'hF0;
    localparam logic [7:0] LOW_MASK_10BIT = 8'hC0;
    localparam int CODE_WIDTH = 12;

    localparam int BIT_MONITOR_RUN    = 0;
    localparam int BIT_PAIR_SEL_LO    = 1;
    localparam int BIT_PAIR_SEL_HI    = 2;
    localparam int BIT_PIN_SEL        = 3;
    localparam int BIT_RESERVED_ZERO  = 4;
    localparam int BIT_ALERT_DISABLE  = 5;
    localparam int BIT_ALERT_POLARITY = 6;
    localparam int BIT_STANDBY        = 7;

    localparam logic [1:0] PAIR_ANALOG_INPUTS = 2'b00;
    localparam logic [1:0] PAIR_DIODE_SENSOR  = 2'b10;

    typedef struct packed {
        logic       write_en;
        logic       read_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dccr_req_s;

    typedef struct packed {
        logic       standby_request;
        logic       alert_polarity;
        logic       alert_output_disable;
        logic       reserved_zero_bit;
        logic       shared_pin_function_select;
        logic [1:0] shared_pair_function_select;
        logic       monitor_run;
    } dccr_cfg_s;

endpackage

// *** hw/dccr_chan_reg.sv ***
module dccr_chan_reg
    import dccr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  low_mask,
    output logic      [7:0]  low_q,
    output logic      [7:0]  high_q
);
    logic [7:0] low_d;
    logic [7:0] high_d;

    always_comb
    begin
        low_d  = low_q & low_mask;
        high_d = high_q;
        if (wr_low)
        begin
            low_d = wdata & low_mask;
        end
        if (wr_high)
        begin
            high_d = wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            low_q  <= RESET_BYTE;
            high_q <= RESET_BYTE;
        end
        else
        begin
            low_q  <= low_d;
            high_q <= high_d;
        end
    end

    a_unused_low_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (low_q & ~low_mask) == 8'h00)
        else $error("unused low bits not zero");

endmodule // dccr_chan_reg

// *** hw/dccr_regs.sv ***
module dccr_regs
    import dccr_pkg::*;
#(
    parameter bit WIDE_VARIANT = 1'b1
)
(
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  wire dccr_req_s             req,
    input  wire logic                  output_load_strobe_n,
    input  wire logic                  load_source_select,
    input  wire logic                  alert_event,
    output logic      [7:0]            rdata_q,
    output logic                       rvalid_q,
    output dccr_cfg_s                  cfg_q,
    output logic [CODE_WIDTH-1:0]      analog_out_b_q,
    output logic [CODE_WIDTH-1:0]      analog_out_c_q,
    output logic [CODE_WIDTH-1:0]      analog_out_d_q,
    output logic                       converters_powered_q,
    output logic                       monitor_active_q,
    output logic                       cyclic_mode_q,
    output logic                       pair_analog_inputs_q,
    output logic                       pair_diode_sensor_q,
    output logic                       analog_input_three_q,
    output logic                       alert_pin_q
);
    localparam logic [7:0] LOW_MASK = WIDE_VARIANT ? LOW_MASK_12BIT : LOW_MASK_10BIT;

    logic [7:0] b_low, b_high, c_low, c_high, d_low, d_high;
    logic       wr;
    dccr_cfg_s  cfg_d;
    logic [7:0] rdata_d;
    logic       strobe_s1_q, strobe_s2_q, strobe_s3_q;
    logic       strobe_fall;
    logic       transfer;
    logic [CODE_WIDTH-1:0] out_b_d, out_c_d, out_d_d;
    logic       converters_powered_d;
    logic       monitor_active_d;
    logic       cyclic_mode_d;
    logic       pair_analog_inputs_d;
    logic       pair_diode_sensor_d;
    logic       analog_input_three_d;
    logic       alert_pin_d;
    logic [1:0] pair_sel;

    assign wr = req.write_en;

    // one instance per channel
    dccr_chan_reg u_chan_b (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .wr_low   (wr && req.addr == ADDR_CHAN_B_LOW),
        .wr_high  (wr && req.addr == ADDR_CHAN_B_HIGH),
        .wdata    (req.wdata),
        .low_mask (LOW_MASK),
        .low_q    (b_low),
        .high_q   (b_high)
    );
    dccr_chan_reg u_chan_c (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .wr_low   (wr && req.addr == ADDR_CHAN_C_LOW),
        .wr_high  (wr && req.addr == ADDR_CHAN_C_HIGH),
        .wdata    (req.wdata),
        .low_mask (LOW_MASK),
        .low_q    (c_low),
        .high_q   (c_high)
    );
    dccr_chan_reg u_chan_d (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .wr_low   (wr && req.addr == ADDR_CHAN_D_LOW),
        .wr_high  (wr && req.addr == ADDR_CHAN_D_HIGH),
        .wdata    (req.wdata),
        .low_mask (LOW_MASK),
        .low_q    (d_low),
        .high_q   (d_high)
    );

    // control register and read mux; both work in standby
    always_comb
    begin
        cfg_d = cfg_q;
        if (wr && req.addr == ADDR_PRIMARY_CFG)
        begin
            cfg_d = dccr_cfg_s'(req.wdata);
        end
        rdata_d = rdata_q;
        if (req.read_en)
        begin
            unique case (req.addr)
                ADDR_CHAN_B_LOW:  rdata_d = b_low;
                ADDR_CHAN_B_HIGH: rdata_d = b_high;
                ADDR_CHAN_C_LOW:  rdata_d = c_low;
                ADDR_CHAN_C_HIGH: rdata_d = c_high;
                ADDR_CHAN_D_LOW:  rdata_d = d_low;
                ADDR_CHAN_D_HIGH: rdata_d = d_high;
                ADDR_PRIMARY_CFG: rdata_d = 8'(cfg_q);
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    // strobe pin synchroniser and falling edge
    assign strobe_fall = strobe_s3_q && !strobe_s2_q;
    assign transfer = cfg_q.shared_pin_function_select ? 1'b1
                    : (load_source_select ? 1'b1 : strobe_fall);

    function automatic logic [CODE_WIDTH-1:0] join_code(input logic [7:0] hi, input logic [7:0] lo);
        join_code = WIDE_VARIANT ? {hi, lo[7:4]} : {2'b00, hi, lo[7:6]};
    endfunction

    always_comb
    begin
        out_b_d = analog_out_b_q;
        out_c_d = analog_out_c_q;
        out_d_d = analog_out_d_q;
        if (cfg_q.standby_request)
        begin
            out_b_d = '0;
            out_c_d = '0;
            out_d_d = '0;
        end
        else if (transfer)
        begin
            out_b_d = join_code(b_high, b_low);
            out_c_d = join_code(c_high, c_low);
            out_d_d = join_code(d_high, d_low);
        end
    end

    // status levels trail the control register by one cycle
    assign pair_sel = cfg_q.shared_pair_function_select;

    always_comb
    begin
        converters_powered_d = !cfg_q.standby_request;
        monitor_active_d     = cfg_q.monitor_run && !cfg_q.standby_request;
        cyclic_mode_d        = 1'b1;
        pair_analog_inputs_d = pair_sel == PAIR_ANALOG_INPUTS;
        pair_diode_sensor_d  = pair_sel == PAIR_DIODE_SENSOR;
        analog_input_three_d = cfg_q.shared_pin_function_select;
        alert_pin_d          = !cfg_q.alert_polarity;
        if (alert_event && !cfg_q.alert_output_disable)
        begin
            alert_pin_d = cfg_q.alert_polarity;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cfg_q                <= dccr_cfg_s'(RESET_BYTE);
            rdata_q              <= RESET_BYTE;
            rvalid_q             <= 1'b0;
            strobe_s1_q          <= 1'b1;
            strobe_s2_q          <= 1'b1;
            strobe_s3_q          <= 1'b1;
            analog_out_b_q       <= '0;
            analog_out_c_q       <= '0;
            analog_out_d_q       <= '0;
            converters_powered_q <= 1'b1;
            monitor_active_q     <= 1'b0;
            cyclic_mode_q        <= 1'b1;
            pair_analog_inputs_q <= 1'b1;
            pair_diode_sensor_q  <= 1'b0;
            analog_input_three_q <= 1'b0;
            alert_pin_q          <= 1'b1;
        end
        else
        begin
            cfg_q                <= cfg_d;
            rdata_q              <= rdata_d;
            rvalid_q             <= req.read_en;
            strobe_s1_q          <= output_load_strobe_n;
            strobe_s2_q          <= strobe_s1_q;
            strobe_s3_q          <= strobe_s2_q;
            analog_out_b_q       <= out_b_d;
            analog_out_c_q       <= out_c_d;
            analog_out_d_q       <= out_d_d;
            converters_powered_q <= converters_powered_d;
            monitor_active_q     <= monitor_active_d;
            cyclic_mode_q        <= cyclic_mode_d;
            pair_analog_inputs_q <= pair_analog_inputs_d;
            pair_diode_sensor_q  <= pair_diode_sensor_d;
            analog_input_three_q <= analog_input_three_d;
            alert_pin_q          <= alert_pin_d;
        end
    end

    a_standby_zero_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_q.standby_request |=> analog_out_b_q == '0 && analog_out_c_q == '0)
        else $error("outputs not zero in standby");
    a_standby_power: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_q.standby_request == 1'b0 |=> converters_powered_q)
        else $error("converters not powered after leaving standby");
    a_monitor_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        monitor_active_q |-> $past(cfg_q.monitor_run))
        else $error("monitoring without enable");
    a_cfg_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && req.addr == ADDR_PRIMARY_CFG) |=> 8'(cfg_q) == $past(req.wdata))
        else $error("control write not stored");
    a_cfg_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req.read_en && req.addr == ADDR_PRIMARY_CFG && !wr) |=> rdata_q == 8'(cfg_q))
        else $error("control readback wrong");
    a_alert_disabled: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_q.alert_output_disable |=> alert_pin_q == !$past(cfg_q.alert_polarity))
        else $error("alert driven while disabled");
    a_input3_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_q.shared_pin_function_select && !cfg_q.standby_request)
        |=> analog_out_b_q == join_code($past(b_high), $past(b_low)))
        else $error("strobe not masked");
    a_pair_decode: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pair_diode_sensor_q |-> !pair_analog_inputs_q)
        else $error("pair select conflict");
    a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req.read_en && (req.addr < ADDR_CHAN_B_LOW || req.addr > ADDR_PRIMARY_CFG))
        |=> rdata_q == 8'h00)
        else $error("unmapped read not zero");

    // reset state and status levels
    a_reset_clear: assert property (@(posedge ref_clk)
        $fell(sys_rst) |-> 8'(cfg_q) == RESET_BYTE && analog_out_b_q == '0
            && analog_out_c_q == '0 && analog_out_d_q == '0)
        else $error("state not cleared by reset");
    a_monitor_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_q.monitor_run && !cfg_q.standby_request) |=> monitor_active_q)
        else $error("monitoring not started");
    a_standby_down: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_q.standby_request |=> !converters_powered_q && !monitor_active_q)
        else $error("standby left converters running");
    a_standby_out_d: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_q.standby_request |=> analog_out_d_q == '0)
        else $error("channel d not zero in standby");
    a_pin_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> analog_input_three_q == $past(cfg_q.shared_pin_function_select))
        else $error("shared pin function not followed");
    a_pair_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> pair_diode_sensor_q
            == ($past(cfg_q.shared_pair_function_select) == PAIR_DIODE_SENSOR))
        else $error("diode sensor select not followed");
    a_pair_inputs: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> pair_analog_inputs_q
            == ($past(cfg_q.shared_pair_function_select) == PAIR_ANALOG_INPUTS))
        else $error("analog input pair select not followed");
    a_alert_active: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (alert_event && !cfg_q.alert_output_disable)
        |=> alert_pin_q == $past(cfg_q.alert_polarity))
        else $error("alert not at active level");
    a_alert_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!alert_event && !cfg_q.alert_output_disable)
        |=> alert_pin_q == !$past(cfg_q.alert_polarity))
        else $error("alert not at idle level");

    // load path and register contents
    a_strobe_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (strobe_fall && !cfg_q.shared_pin_function_select && !cfg_q.standby_request)
        |=> analog_out_b_q == join_code($past(b_high), $past(b_low)))
        else $error("strobe did not load codes");
    a_strobe_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!transfer && !cfg_q.standby_request) |=> $stable(analog_out_b_q))
        else $error("codes moved without a load");
    a_code_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && req.addr == ADDR_CHAN_C_HIGH) |=> c_high == $past(req.wdata))
        else $error("high byte write lost");
    a_code_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && req.addr == ADDR_CHAN_D_LOW) |=> d_low == ($past(req.wdata) & LOW_MASK))
        else $error("low byte write not masked");
    a_high_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(wr && req.addr == ADDR_CHAN_B_HIGH) |=> $stable(b_high))
        else $error("high byte changed without write");
    a_low_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req.read_en && req.addr == ADDR_CHAN_B_LOW) |=> (rdata_q & ~LOW_MASK) == 8'h00)
        else $error("unused low bits read back");
    a_read_valid: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req.read_en |=> rvalid_q)
        else $error("read not answered");
    a_read_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !req.read_en |=> $stable(rdata_q))
        else $error("read data changed without read");
    a_unmapped_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && req.addr > ADDR_PRIMARY_CFG) |=> $stable(cfg_q))
        else $error("unmapped write changed control");

endmodule // dccr_regs

// *** verif/dccr_host.sv ***
module dccr_host
    import dccr_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rvalid_q,
    input  wire logic [7:0] rdata_q,
    output dccr_req_s       req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        if (a == ADDR_PRIMARY_CFG)
        begin
            d[BIT_RESERVED_ZERO] = 1'b0;
        end
        req = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk);
        // released bus shows no stale value
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge ref_clk);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk);
        req = '{1'b0, 1'b0, ~a, 8'hFF};
        n = 0;
        while (rvalid_q !== 1'b1 && n < 4)
        begin
            @(negedge ref_clk);
            n++;
        end
        d = (rvalid_q === 1'b1) ? rdata_q : 8'hxx;
    endtask
endmodule // dccr_host

// *** verif/dccr_regs_bench.sv ***
module dccr_regs_bench
    import dccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            ref_clk;
    logic            sys_rst;
    dccr_req_s       req;
    logic            strobe_n;
    logic            lss;
    logic            alert_event;
    logic [7:0]      rdata_q;
    logic            rvalid_q;
    dccr_cfg_s       cfg_q;
    logic [11:0]     outs [3];
    logic [11:0]     narrow_b;
    logic            pwr_q, mon_q, cyc_q, pai_q, pds_q, ai3_q, alert_q;
    int              fail_count = 0;
    int              check_count = 0;
    localparam logic [7:0] CFG_V [6] = '{8'h01, 8'h04, 8'h00, 8'h40, 8'h60, 8'h20};
    localparam logic [2:0] EXP_V [6] = '{3'b100, 3'b010, 3'b000, 3'b001, 3'b000, 3'b001};

    dccr_host u_dccr_host (.ref_clk(ref_clk), .rvalid_q(rvalid_q), .rdata_q(rdata_q), .req(req));

    dccr_regs u_dccr_regs (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .output_load_strobe_n(strobe_n),
        .load_source_select(lss), .alert_event(alert_event), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .cfg_q(cfg_q), .analog_out_b_q(outs[0]),
        .analog_out_c_q(outs[1]), .analog_out_d_q(outs[2]), .converters_powered_q(pwr_q),
        .monitor_active_q(mon_q), .cyclic_mode_q(cyc_q), .pair_analog_inputs_q(pai_q),
        .pair_diode_sensor_q(pds_q), .analog_input_three_q(ai3_q), .alert_pin_q(alert_q)
    );

    // 10-bit variant on the same request stream
    dccr_regs #(.WIDE_VARIANT(1'b0)) u_dccr_regs_narrow (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .output_load_strobe_n(strobe_n),
        .load_source_select(lss), .alert_event(alert_event), .rdata_q(), .rvalid_q(),
        .cfg_q(), .analog_out_b_q(narrow_b), .analog_out_c_q(), .analog_out_d_q(),
        .converters_powered_q(), .monitor_active_q(), .cyclic_mode_q(),
        .pair_analog_inputs_q(), .pair_diode_sensor_q(), .analog_input_three_q(),
        .alert_pin_q()
    );

    always #25 ref_clk = ~ref_clk;

    task automatic check(input logic [11:0] s, input logic [11:0] e);
        check_count++;
        if (s !== e)
        begin
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
            fail_count++;
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_dccr_host.read(a, d);
        check({4'h0, d}, {4'h0, e});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #200000;
        fail_count++;
        results();
    end

    initial
    begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        strobe_n = 1'b1;
        lss = 1'b1;
        alert_event = 1'b0;
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 7; i++)
            rc(ADDR_CHAN_B_LOW + 8'(i), RESET_BYTE);
        check(outs[0], 12'h000);
        check({7'h00, pwr_q, cyc_q, mon_q, pai_q, alert_q}, 12'h01B);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            u_dccr_host.write(ADDR_CHAN_B_LOW + 8'(2 * i), 8'hFF);
            u_dccr_host.write(ADDR_CHAN_B_HIGH + 8'(2 * i), 8'h5A ^ 8'(i));
            rc(ADDR_CHAN_B_LOW + 8'(2 * i), LOW_MASK_12BIT);
            rc(ADDR_CHAN_B_HIGH + 8'(2 * i), 8'h5A ^ 8'(i));
            check(outs[i], {8'h5A ^ 8'(i), 4'hF});
        end
        check(narrow_b, 12'h16B);
        u_dccr_host.write(8'h20, 8'hA5);
        rc(8'h20, 8'h00);
        $display("test codes done");
        lss = 1'b0;
        u_dccr_host.write(ADDR_CHAN_B_HIGH, 8'h33);
        repeat (6) @(negedge ref_clk);
        check(outs[0], 12'h5AF);
        strobe_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        strobe_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        check(outs[0], 12'h33F);
        u_dccr_host.write(ADDR_PRIMARY_CFG, 8'h08);
        u_dccr_host.write(ADDR_CHAN_B_HIGH, 8'h44);
        repeat (6) @(negedge ref_clk);
        check(outs[0], 12'h44F);
        check({11'h000, ai3_q}, 12'h001);
        $display("test strobe done");
        alert_event = 1'b1;
        // only the defined pair codes 00 and 10 are written
        for (int i = 0; i < 6; i++)
        begin
            u_dccr_host.write(ADDR_PRIMARY_CFG, CFG_V[i]);
            repeat (2) @(negedge ref_clk);
            check({9'h000, mon_q, pds_q, alert_q}, {9'h000, EXP_V[i]});
            rc(ADDR_PRIMARY_CFG, CFG_V[i]);
        end
        $display("test config done");
        lss = 1'b1;
        u_dccr_host.write(ADDR_PRIMARY_CFG, 8'h81);
        repeat (2) @(negedge ref_clk);
        check({11'h000, pwr_q}, 12'h000);
        check({11'h000, mon_q}, 12'h000);
        check(outs[1], 12'h000);
        rc(ADDR_PRIMARY_CFG, 8'h81);
        u_dccr_host.write(ADDR_CHAN_C_HIGH, 8'h77);
        rc(ADDR_CHAN_C_HIGH, 8'h77);
        u_dccr_host.write(ADDR_PRIMARY_CFG, 8'h00);
        repeat (3) @(negedge ref_clk);
        check({11'h000, pwr_q}, 12'h001);
        check(outs[1], 12'h77F);
        $display("test standby done");
        results();
    end
endmodule // dccr_regs_bench
